// File: core/burst_sram_pkg.sv
/*
 * package for the synchronous burst sram model: widths, cycle kinds, carriers
 * and snooze timing. assumes a single 100 MHz clock.
 */
package burst_sram_pkg;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int ADDR_W = 19;
	localparam int FIFO_DEPTH = 8;
	localparam int CLK_PERIOD_NS = 10;
	// snooze entry bound and exit wait, in clock periods
	localparam int SNOOZE_ENTER_CYC = 2;
	localparam int SNOOZE_EXIT_CYC = 2;
	localparam logic [1:0] BURST_START = 2'h0;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_READ,
		CYC_WRITE,
		CYC_DESEL
	} cycle_t;

	// one sampled bus cycle
	typedef struct packed {
		logic strobe_n;
		logic chip_sel_n;
		logic gate_n;
		logic [LANES-1:0] lane_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_in_t;

	// write word queued towards the array
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lanes;
		logic [DATA_W-1:0] data;
	} wr_word_t;
endpackage

// File: core/write_fifo.sv
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module write_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << PW) != DEPTH) $error("fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wp_q;
	logic [PW:0] rp_q;
	logic [WIDTH-1:0] rd_q;
	logic rd_valid_q;

	wire full = (wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]);
	wire empty = (wp_q == rp_q);
	wire push = in_valid && !full;
	// output register refills when empty or consumed
	wire load = !empty && (!rd_valid_q || out_ready);

	assign in_ready = !full;
	assign out_valid = rd_valid_q;
	assign out_data = rd_q;

	always_ff @(posedge clk) begin
		if (push) mem[wp_q[PW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_q <= '0;
			rp_q <= '0;
			rd_q <= '0;
			rd_valid_q <= 1'b0;
		end else begin
			if (push) wp_q <= wp_q + 1'b1;
			if (load) begin
				rd_q <= mem[rp_q[PW-1:0]];
				rp_q <= rp_q + 1'b1;
				rd_valid_q <= 1'b1;
			end else if (out_ready) begin
				rd_valid_q <= 1'b0;
			end
		end
	end
endmodule

// File: core/burst_sram.sv
/*
 * cycle qualification, burst sequencing and snooze gating of a 32-bit
 * synchronous pipelined burst sram, with an array behind a write fifo.
 * assumes the controller meets setup/hold and the snooze rules; nrst is a
 * model-level reset only, the memory has no reset pin.
 */
// Behaviour
// - while snooze request is high, stay deselected in standby until it falls.
// - in snooze, ignore all inputs except the snooze request.
// - start ignoring inputs at most two clocks after snooze request rises.
// - global gate low with any lane write enable low at an edge makes a write cycle.
// - all lane enables high and address strobe low makes a read cycle.
// - output enable is ignored while the global gate and any lane write enable are low.
// - global gate and all lane enables low together write every lane.
// - output enable does not drive read data before the next rising edge.
// - burst-order select behaves high when left unconnected.
// - continued burst cycles access the next internal burst address.
// - low burst-order select is linear, high is interleaved.
// - address strobe aborts a burst, loads a new address, starts access.
// - strobe low with chip select high deselects, outputs high impedance.
`timescale 1ns/1ps
module burst_sram
	import burst_sram_pkg::*;
#(
	parameter int WORDS = 1024
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic snooze_request,
	input wire logic address_strobe_n,
	input wire logic chip_select_n,
	input wire logic global_byte_write_gate_n,
	input wire logic lane0_write_n,
	input wire logic lane1_write_n,
	input wire logic lane2_write_n,
	input wire logic lane3_write_n,
	input wire logic output_enable_n,
	input wire logic burst_order_sel,
	input wire logic burst_order_sel_oe_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_n,
	output logic snoozing,
	output logic write_stall
);
	localparam int IDX_W = $clog2(WORDS);

	initial begin
		if (WORDS < 4 || WORDS > (1 << ADDR_W)) $error("array size out of range");
	end

	// ==================================================================
	// pin synchronisers
	// ==================================================================
	// snooze and output enable are asynchronous pins, so each passes two flops
	logic zz_s1_q;
	logic zz_s2_q;
	logic oe_s1_q;
	logic oe_s2_q;
	logic mode_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			zz_s1_q <= 1'b0;
			zz_s2_q <= 1'b0;
			oe_s1_q <= 1'b1;
			oe_s2_q <= 1'b1;
		end else begin
			zz_s1_q <= snooze_request;
			zz_s2_q <= zz_s1_q;
			oe_s1_q <= output_enable_n;
			oe_s2_q <= oe_s1_q;
		end
	end

	// an undriven mode pin reads as the pull-up level
	wire mode_pin = burst_order_sel_oe_n ? 1'b1 : burst_order_sel;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) mode_q <= 1'b1;
		else mode_q <= mode_pin;
	end

	// ==================================================================
	// input register and cycle decode
	// ==================================================================
	bus_in_t in_q;
	logic in_valid_q;

	// synchronous inputs are registered at every edge; in snooze they are flagged not valid
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_q <= '{strobe_n: 1'b1, chip_sel_n: 1'b1, gate_n: 1'b1, lane_n: 4'hF,
				addr: '0, wdata: DATA_RESET};
			in_valid_q <= 1'b0;
		end else begin
			in_q <= '{strobe_n: address_strobe_n, chip_sel_n: chip_select_n,
				gate_n: global_byte_write_gate_n,
				lane_n: {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n},
				addr: address, wdata: data_in};
			in_valid_q <= !zz_s2_q;
		end
	end

	wire [LANES-1:0] lane_sel = ~in_q.lane_n;
	wire any_lane = |lane_sel;
	wire write_hit = any_lane && !in_q.gate_n;
	wire read_hit = !any_lane && !in_q.strobe_n;
	wire all_lanes = !in_q.gate_n && (lane_sel == 4'hF);
	wire new_addr = !in_q.strobe_n;
	wire desel_hit = new_addr && in_q.chip_sel_n;

	// ==================================================================
	// burst sequencing
	// ==================================================================
	function automatic logic [1:0] burst_low(input logic linear, input logic [1:0] base, input logic [1:0] cnt);
		burst_low = linear ? 2'(base + cnt) : (base ^ cnt);
	endfunction

	logic [ADDR_W-1:0] base_q;
	logic [1:0] cnt_q;
	logic selected_q;
	logic first_q;
	cycle_t cyc_q;

	wire active = in_valid_q && !zz_s2_q;
	// any strobe-high edge of a selected burst moves on, reads and writes alike
	wire cont = active && !new_addr && selected_q;
	wire [1:0] next_cnt = first_q ? cnt_q : 2'(cnt_q + 2'h1);
	wire [ADDR_W-1:0] cur_addr = new_addr ? in_q.addr
		: {base_q[ADDR_W-1:2], burst_low(!mode_q, base_q[1:0], next_cnt)};

	wire selected_q_n_ok = new_addr ? !in_q.chip_sel_n : selected_q;
	wire cyc_write = active && selected_q_n_ok && write_hit;
	wire cyc_read = active && selected_q_n_ok && !write_hit && (new_addr || (!any_lane && selected_q));

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			base_q <= '0;
			cnt_q <= BURST_START;
			selected_q <= 1'b0;
			first_q <= 1'b1;
			cyc_q <= CYC_IDLE;
		end else if (!active) begin
			selected_q <= 1'b0;
			first_q <= 1'b1;
			cyc_q <= CYC_IDLE;
		end else if (new_addr) begin
			base_q <= in_q.addr;
			cnt_q <= BURST_START;
			first_q <= 1'b0;
			selected_q <= !in_q.chip_sel_n;
			cyc_q <= desel_hit ? CYC_DESEL : (write_hit ? CYC_WRITE : CYC_READ);
		end else if (cont) begin
			cnt_q <= next_cnt;
			first_q <= 1'b0;
			cyc_q <= write_hit ? CYC_WRITE : CYC_READ;
		end else begin
			cyc_q <= CYC_IDLE;
		end
	end

	// ==================================================================
	// write path through the fifo, array and read pipeline
	// ==================================================================
	wr_word_t push_word;
	wr_word_t pop_word;
	logic push_ready;
	logic pop_valid;
	logic [DATA_W-1:0] mem [WORDS];

	assign push_word = '{addr: cur_addr,
		lanes: all_lanes ? 4'hF : (in_q.gate_n ? 4'h0 : lane_sel), data: in_q.wdata};

	write_fifo #(.WIDTH($bits(wr_word_t)), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(cyc_write),
		.in_ready(push_ready),
		.in_data(push_word),
		.out_valid(pop_valid),
		.out_ready(1'b1),
		.out_data(pop_word)
	);

	always_ff @(posedge clk) begin
		if (pop_valid) begin
			for (int i = 0; i < LANES; i++) begin
				if (pop_word.lanes[i]) mem[pop_word.addr[IDX_W-1:0]][8*i +: 8] <= pop_word.data[8*i +: 8];
			end
		end
	end

	// read returns pending fifo data would be a hazard; reads see the array after drain
	logic [DATA_W-1:0] rdata_q;
	logic rvalid_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= DATA_RESET;
			rvalid_q <= 1'b0;
			data_out <= DATA_RESET;
			data_oe_n <= 1'b1;
			snoozing <= 1'b0;
			write_stall <= 1'b0;
		end else begin
			rdata_q <= mem[cur_addr[IDX_W-1:0]];
			rvalid_q <= cyc_read;
			data_out <= rdata_q;
			// drive only for a registered read, oe sampled low, no write lane low with the gate low
			data_oe_n <= !(rvalid_q && !oe_s2_q && !write_hit && active);
			snoozing <= zz_s2_q;
			write_stall <= !push_ready;
		end
	end

	// ==================================================================
	// checks
	// ==================================================================
	a_snooze_gates_input: assert property (@(posedge clk) disable iff (!nrst)
		$rose(snooze_request) |-> ##[1:3] !in_valid_q) else $error("inputs not gated after snooze");
	a_snooze_no_drive: assert property (@(posedge clk) disable iff (!nrst)
		zz_s2_q |=> data_oe_n) else $error("data driven during snooze");
	a_snooze_no_write: assert property (@(posedge clk) disable iff (!nrst)
		zz_s2_q |-> !cyc_write) else $error("write taken in snooze");
	a_write_no_drive: assert property (@(posedge clk) disable iff (!nrst)
		(active && write_hit) |=> data_oe_n) else $error("output driven on write");
	a_desel_hiz: assert property (@(posedge clk) disable iff (!nrst)
		(active && desel_hit) |=> ##1 data_oe_n) else $error("deselect drove outputs");
	a_read_latency: assert property (@(posedge clk) disable iff (!nrst)
		$fell(output_enable_n) |-> data_oe_n [*3]) else $error("output enable acted too early");
	a_all_lanes: assert property (@(posedge clk) disable iff (!nrst)
		(cyc_write && all_lanes) |-> push_word.lanes == 4'hF) else $error("full write lost lanes");
	a_burst_step: assert property (@(posedge clk) disable iff (!nrst)
		(cont && !first_q) |=> cnt_q == $past(cnt_q) + 2'h1) else $error("burst counter did not step");
	a_strobe_loads: assert property (@(posedge clk) disable iff (!nrst)
		(active && new_addr) |=> base_q == $past(in_q.addr) && cnt_q == BURST_START) else $error("strobe lost");
	a_read_kind: assert property (@(posedge clk) disable iff (!nrst)
		(active && read_hit && !in_q.chip_sel_n) |=> cyc_q == CYC_READ) else $error("read not recognised");
endmodule

// File: sim/sram_ctl_model.sv
/*
 * far-side controller model: cyc drives one synchronous bus cycle per call, idle drives n of them.
 * assumes the bench calls its tasks from one process and keeps the bus idle
 * around snooze.
 */
`timescale 1ns/1ps
module sram_ctl_model
	import burst_sram_pkg::*;
(
	input wire logic clk,
	output logic snooze_request,
	output logic address_strobe_n,
	output logic chip_select_n,
	output logic global_byte_write_gate_n,
	output logic [LANES-1:0] lane_n,
	output logic output_enable_n,
	output logic [ADDR_W-1:0] address,
	output logic [DATA_W-1:0] data_in
);
	logic keep_oe;
	initial begin
		{snooze_request, keep_oe, output_enable_n} = 3'h0;
		{address_strobe_n, chip_select_n, global_byte_write_gate_n, lane_n} = 7'h7F;
		address = '0;
		data_in = '0;
	end
	// ===========================================
	// bus cycles
	// every field changes after the falling edge and holds over the rising edge
	task automatic cyc(input logic s_n, input logic cs_n, input logic g_n, input logic [LANES-1:0] ln,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk);
		address_strobe_n = s_n;
		chip_select_n = cs_n;
		global_byte_write_gate_n = g_n;
		lane_n = ln;
		address = a;
		// released data lines toggle so a stale word never looks valid
		data_in = (&ln) ? ~data_in : d;
		// oe high across write data unless keep_oe is set, so the pins never fight
		output_enable_n = (&ln) ? 1'b0 : ~keep_oe;
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		repeat (n) cyc(1'b0, 1'b1, 1'b1, '1, ~address, '0);
	endtask
	// entry is only requested with the bus idle, so nothing is pending at entry
	task automatic snooze(input logic on);
		@(negedge clk);
		snooze_request = on;
		if (!on) idle(SNOOZE_EXIT_CYC + 2);
	endtask
endmodule

// File: sim/burst_sram_bench.sv
/*
 * self-checking bench for burst_sram: byte writes, bursts, write drive,
 * deselect and snooze. assumes sram_ctl_model drives the bus side.
 */
`timescale 1ns/1ps
module burst_sram_bench;
	import burst_sram_pkg::*;
	logic clk, nrst, snooze_request, address_strobe_n, chip_select_n, gate_n, output_enable_n;
	logic burst_order_sel, burst_order_sel_oe_n, data_oe_n, snoozing, write_stall;
	logic [LANES-1:0] lane_n;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] data_in, data_out;
	logic [DATA_W-1:0] mem [0:63];
	int errors, tests_run, cycles;
	sram_ctl_model ctl (.clk(clk), .snooze_request(snooze_request), .address_strobe_n(address_strobe_n),
		.chip_select_n(chip_select_n), .global_byte_write_gate_n(gate_n), .lane_n(lane_n),
		.output_enable_n(output_enable_n), .address(address), .data_in(data_in));
	burst_sram dut (.clk(clk), .nrst(nrst), .snooze_request(snooze_request),
		.address_strobe_n(address_strobe_n), .chip_select_n(chip_select_n),
		.global_byte_write_gate_n(gate_n), .lane0_write_n(lane_n[0]), .lane1_write_n(lane_n[1]),
		.lane2_write_n(lane_n[2]), .lane3_write_n(lane_n[3]), .output_enable_n(output_enable_n),
		.burst_order_sel(burst_order_sel), .burst_order_sel_oe_n(burst_order_sel_oe_n),
		.address(address), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.snoozing(snoozing), .write_stall(write_stall));
	always #5 clk = ~clk;
	// ===========================================
	// checking and closing
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			end_of_test();
		end
	end
	task automatic check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ===========================================
	// access helpers
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln, input logic [DATA_W-1:0] d);
		ctl.cyc(1'b0, 1'b0, 1'b0, ln, a, d);
		for (int i = 0; i < LANES; i++) begin
			if (!ln[i]) mem[a[5:0]][8*i +: 8] = d[8*i +: 8];
		end
	endtask
	// a fresh strobe opens every access; strobe-high edges continue the burst
	task automatic rd(input logic [ADDR_W-1:0] a, input int beats, input logic lin);
		logic [1:0] lo;
		ctl.cyc(1'b0, 1'b0, 1'b1, '1, a, '0);
		// one strobe-high edge: data of the strobed address stands two edges after it
		ctl.cyc(1'b1, 1'b1, 1'b1, '1, ~a, '0);
		#1;
		check("early drive", {31'h0, data_oe_n}, 32'h1);
		for (int i = 0; i < beats; i++) begin
			ctl.cyc(1'b1, 1'b1, 1'b1, '1, ~a, '0);
			#1;
			lo = lin ? a[1:0] + i[1:0] : a[1:0] ^ i[1:0];
			check("read data", data_out, mem[{a[5:2], lo}]);
			check("read drive", {31'h0, data_oe_n}, 32'h0);
		end
		ctl.idle(4);
	endtask
	// ===========================================
	// scenarios
	task automatic t_bytes;
		wr(ADDR_W'(20), 4'h0, 32'h1122_3344);
		for (int i = 0; i < LANES; i++) wr(ADDR_W'(20), ~(4'h1 << i), 32'hA0A0_A0A0 + i);
		ctl.idle(3);
		rd(ADDR_W'(20), 1, 1'b1);
		$display("byte lane test done");
	endtask
	task automatic t_burst;
		for (int i = 0; i < 4; i++) wr(ADDR_W'(8 + i), 4'h0, 32'hB000_0000 + i);
		ctl.idle(3);
		// linear, interleaved driven high, then floating pin over a low level
		for (int m = 0; m < 3; m++) begin
			burst_order_sel = (m == 1);
			burst_order_sel_oe_n = (m == 2);
			ctl.idle(2);
			rd(ADDR_W'(9), 4, m == 0);
		end
		$display("burst order test done");
	endtask
	task automatic t_oe_write;
		ctl.keep_oe = 1'b1;
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_W'(30 + i), 4'hE, 32'h5A5A_0000 + i);
			#1;
			check("drive in write", {31'h0, data_oe_n}, 32'h1);
			check("write stall", {31'h0, write_stall}, 32'h0);
		end
		ctl.keep_oe = 1'b0;
		ctl.idle(3);
		rd(ADDR_W'(35), 1, 1'b1);
		$display("write drive test done");
	endtask
	task automatic t_desel;
		for (int i = 0; i < 4; i++) begin
			ctl.idle(1);
			#1;
			check("deselect drive", {31'h0, data_oe_n}, 32'h1);
		end
		$display("deselect test done");
	endtask
	task automatic t_snooze;
		wr(ADDR_W'(40), 4'h0, 32'hC0DE_0001);
		ctl.idle(3);
		ctl.snooze(1'b1);
		ctl.idle(SNOOZE_ENTER_CYC);
		#1;
		check("standby", {31'h0, snoozing}, 32'h1);
		// writes then reads while asleep: none may land or drive
		for (int i = 0; i < 6; i++) begin
			ctl.cyc(1'b0, 1'b0, 1'b0, (i < 3) ? 4'h0 : 4'hF, ADDR_W'(40), 32'hDEAD_0000);
			#1;
			check("asleep drive", {31'h0, data_oe_n}, 32'h1);
		end
		ctl.snooze(1'b0);
		#1;
		check("awake", {31'h0, snoozing}, 32'h0);
		rd(ADDR_W'(40), 1, 1'b1);
		$display("snooze test done");
	endtask
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		burst_order_sel = 1'b0;
		burst_order_sel_oe_n = 1'b0;
		errors = 0;
		tests_run = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		ctl.idle(2);
		t_bytes();
		t_burst();
		t_oe_write();
		t_desel();
		t_snooze();
		end_of_test();
	end
endmodule
